//--- core/nmn_pkg.sv
// constants, encodings and state types for the negate/multiply/no-op executor
package nmn_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   // opcode fields: top seven bits select the byte-oriented op, bit 8 is the access bit
   localparam logic [6:0] OPC_MUL_F = 7'h01;
   localparam logic [6:0] OPC_NEG_F = 7'h36;
   localparam logic [15:0] OPC_NOP_ZERO = 16'h0000;
   localparam logic [3:0] OPC_NOP_TOP = 4'hF;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 9;
   localparam int ACC_BIT = 8;
   localparam int NOP_TOP_LO = 12;
   // access bank and indexed literal offset split points
   localparam logic [7:0] ACC_SPLIT = 8'h80;
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [3:0] ACC_LOW_PAGE = 4'h0;
   localparam logic [3:0] ACC_SFR_PAGE = 4'hF;
   // flag positions in the flag vector
   localparam int FLAG_W = 5;
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_MIN = 8'h80;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [11:0] ADDR_ZERO = 12'h000;

   typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} nmn_phase_t;
   typedef enum logic [1:0] {OP_NOP, OP_NEG, OP_MUL} nmn_op_t;
endpackage

//--- core/nmn_alu_if.sv
// carrier between the sequencer and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface nmn_alu_if;
   logic [7:0] opnd;
   logic [7:0] wreg;
   logic [7:0] neg_res;
   logic [4:0] neg_flags;
   logic [15:0] prod;
   modport alu (input opnd, input wreg, output neg_res, output neg_flags, output prod);
   modport seq (output opnd, output wreg, input neg_res, input neg_flags, input prod);
endinterface
`default_nettype wire

//--- core/nmn_alu.sv
// arithmetic unit: two's complement negate with flags, and unsigned 8x8 multiply
`timescale 1ns/1ps
`default_nettype none
module nmn_alu (
   nmn_alu_if.alu a
);
   logic [8:0] sum;
   always_comb begin
      // negate as ~f + 1 so carry falls out of the adder; digit carry is set when the low nibble of f is zero
      sum = {1'b0, ~a.opnd} + 9'h001;
      a.neg_res = sum[7:0];
      a.neg_flags[nmn_pkg::FLG_C] = sum[8];
      a.neg_flags[nmn_pkg::FLG_DC] = (a.opnd[3:0] == nmn_pkg::NIB_ZERO);
      a.neg_flags[nmn_pkg::FLG_Z] = (sum[7:0] == nmn_pkg::BYTE_ZERO);
      a.neg_flags[nmn_pkg::FLG_OV] = (a.opnd == nmn_pkg::BYTE_MIN);
      a.neg_flags[nmn_pkg::FLG_N] = sum[7];
      // widen before multiplying so the high byte is not lost
      a.prod = 16'(a.wreg) * 16'(a.opnd);
   end
endmodule
`default_nettype wire

//--- core/nmn_exec.sv
// four-phase executor for negate-file, multiply-w-by-file and no-op words
// How it works
// - negate-file replaces the byte with its two's complement, updates N OV C DC Z.
// - the negated value goes back to the same data byte, never to W.
// - access bit 0 maps the file address into the access bank, bank ignored.
// - access bit 1 uses the bank select register to pick the bank.
// - access bit 0 with extended set: addresses up to 5Fh are indexed offsets.
// - negate is one word, one cycle: decode, read, compute, write.
// - multiply keeps W and the file byte, writes only the product pair in phase four.
// - multiply forms unsigned 16-bit W times file byte, high byte upper, no flags.
`timescale 1ns/1ps
`default_nettype none
module nmn_exec #(
   parameter int ADDR_W = nmn_pkg::ADDR_W
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_word_in,
   input wire logic [3:0] bank_select_register_in,
   input wire logic ext_set_in,
   input wire logic [11:0] index_base_in,
   input wire logic [7:0] w_in,
   input wire logic [7:0] mem_rdata_in,
   output logic instr_ready_out,
   output logic [11:0] mem_addr_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   output logic [7:0] mem_wdata_out,
   output logic [4:0] flags_out,
   output logic flags_we_out,
   output logic [7:0] product_high_byte_out,
   output logic [7:0] product_low_byte_out,
   output logic prod_we_out,
   output logic done_out
);
   if (ADDR_W != nmn_pkg::ADDR_W) begin : g_chk
      $error("nmn_exec: address width must be 12");
   end

   typedef struct packed {
      nmn_pkg::nmn_phase_t ph;
      nmn_pkg::nmn_op_t op;
      logic [15:0] word;
      logic [11:0] addr;
      logic [7:0] res;
      logic [4:0] new_flags;
      logic [15:0] prod_new;
      logic [4:0] flags;
      logic [15:0] prod;
   } nmn_state_t;

   nmn_state_t s_q, s_d;
   nmn_alu_if alu_bus ();

   nmn_alu u_alu (
      .a(alu_bus.alu)
   );

   function automatic nmn_pkg::nmn_op_t op_of(input logic [15:0] w);
      if (w[nmn_pkg::OPC_HI:nmn_pkg::OPC_LO] == nmn_pkg::OPC_NEG_F) begin
         return nmn_pkg::OP_NEG;
      end
      if (w[nmn_pkg::OPC_HI:nmn_pkg::OPC_LO] == nmn_pkg::OPC_MUL_F) begin
         return nmn_pkg::OP_MUL;
      end
      // zero word, top nibble all ones, and anything unhandled fall through as no-op
      return nmn_pkg::OP_NOP;
   endfunction

   function automatic logic [11:0] addr_of(input logic [15:0] w, input logic [3:0] bank,
                                           input logic ext, input logic [11:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (w[nmn_pkg::ACC_BIT]) begin
         return {bank, f};
      end
      if (ext && (f <= nmn_pkg::IDX_LIMIT)) begin
         return 12'(base + {4'h0, f});
      end
      // low half of the access bank is ram page zero, high half the special registers
      if (f < nmn_pkg::ACC_SPLIT) begin
         return {nmn_pkg::ACC_LOW_PAGE, f};
      end
      return {nmn_pkg::ACC_SFR_PAGE, f};
   endfunction

   assign alu_bus.opnd = mem_rdata_in;
   assign alu_bus.wreg = w_in;

   always_comb begin
      s_d = s_q;
      case (s_q.ph)
         nmn_pkg::PH_IDLE: begin
            if (instr_valid_in) begin
               s_d.word = instr_word_in;
               s_d.ph = nmn_pkg::PH_Q1;
            end
         end
         nmn_pkg::PH_Q1: begin
            // decode, and resolve the operand address from the bank state of this cycle
            s_d.op = op_of(s_q.word);
            s_d.addr = addr_of(s_q.word, bank_select_register_in, ext_set_in, index_base_in);
            s_d.ph = nmn_pkg::PH_Q2;
         end
         nmn_pkg::PH_Q2: begin
            s_d.ph = nmn_pkg::PH_Q3;
         end
         nmn_pkg::PH_Q3: begin
            // read data arrives one cycle after the read strobe
            s_d.res = alu_bus.neg_res;
            s_d.new_flags = alu_bus.neg_flags;
            s_d.prod_new = alu_bus.prod;
            s_d.ph = nmn_pkg::PH_Q4;
         end
         nmn_pkg::PH_Q4: begin
            if (s_q.op == nmn_pkg::OP_NEG) begin
               s_d.flags = s_q.new_flags;
            end
            if (s_q.op == nmn_pkg::OP_MUL) begin
               s_d.prod = s_q.prod_new;
            end
            // next word may be taken in the write phase for back-to-back cycles
            if (instr_valid_in) begin
               s_d.word = instr_word_in;
               s_d.ph = nmn_pkg::PH_Q1;
            end else begin
               s_d.ph = nmn_pkg::PH_IDLE;
            end
         end
         default: begin
            s_d.ph = nmn_pkg::PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s_q <= '{ph: nmn_pkg::PH_IDLE, op: nmn_pkg::OP_NOP, word: nmn_pkg::WORD_ZERO,
                  addr: nmn_pkg::ADDR_ZERO, res: nmn_pkg::BYTE_ZERO,
                  new_flags: nmn_pkg::FLAGS_RST, prod_new: nmn_pkg::WORD_ZERO,
                  flags: nmn_pkg::FLAGS_RST, prod: nmn_pkg::WORD_ZERO};
      end else begin
         s_q <= s_d;
      end
   end

   assign instr_ready_out = (s_q.ph == nmn_pkg::PH_IDLE) || (s_q.ph == nmn_pkg::PH_Q4);
   assign mem_addr_out = s_q.addr;
   assign mem_rd_out = (s_q.ph == nmn_pkg::PH_Q2) && (s_q.op != nmn_pkg::OP_NOP);
   // only negate writes memory, and to the address it read from
   assign mem_wr_out = (s_q.ph == nmn_pkg::PH_Q4) && (s_q.op == nmn_pkg::OP_NEG);
   assign mem_wdata_out = s_q.res;
   assign flags_we_out = mem_wr_out;
   assign flags_out = s_q.flags;
   assign prod_we_out = (s_q.ph == nmn_pkg::PH_Q4) && (s_q.op == nmn_pkg::OP_MUL);
   assign product_high_byte_out = s_q.prod[15:8];
   assign product_low_byte_out = s_q.prod[7:0];
   assign done_out = (s_q.ph == nmn_pkg::PH_Q4);

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_neg_value;
      (s_q.ph == nmn_pkg::PH_Q3) && (s_q.op == nmn_pkg::OP_NEG)
         |=> mem_wr_out && (mem_wdata_out == 8'(8'h00 - $past(mem_rdata_in)));
   endproperty
   a_neg_value: assert property (p_neg_value) else $error("negate result wrong");

   property p_neg_flags;
      mem_wr_out |=> (flags_out[nmn_pkg::FLG_Z] == ($past(mem_wdata_out) == 8'h00))
         && (flags_out[nmn_pkg::FLG_N] == $past(mem_wdata_out[7]));
   endproperty
   a_neg_flags: assert property (p_neg_flags) else $error("negate flags wrong");

   property p_neg_same_addr;
      mem_rd_out && (s_q.op == nmn_pkg::OP_NEG)
         |-> ##2 mem_wr_out && (mem_addr_out == $past(mem_addr_out, 2));
   endproperty
   a_neg_same_addr: assert property (p_neg_same_addr) else $error("write address moved");

   property p_access_bank;
      (s_q.ph == nmn_pkg::PH_Q1) && !s_q.word[nmn_pkg::ACC_BIT] && !ext_set_in
         |=> (mem_addr_out[7:0] == $past(s_q.word[7:0]))
            && (mem_addr_out[11:8] == ($past(s_q.word[7]) ? nmn_pkg::ACC_SFR_PAGE
                                                          : nmn_pkg::ACC_LOW_PAGE));
   endproperty
   a_access_bank: assert property (p_access_bank) else $error("access bank map wrong");

   property p_bank_sel;
      (s_q.ph == nmn_pkg::PH_Q1) && s_q.word[nmn_pkg::ACC_BIT]
         |=> mem_addr_out == {$past(bank_select_register_in), $past(s_q.word[7:0])};
   endproperty
   a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

   property p_indexed;
      (s_q.ph == nmn_pkg::PH_Q1) && !s_q.word[nmn_pkg::ACC_BIT] && ext_set_in
         && (s_q.word[7:0] <= nmn_pkg::IDX_LIMIT)
         |=> mem_addr_out == 12'($past(index_base_in) + {4'h0, $past(s_q.word[7:0])});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_one_cycle;
      instr_valid_in && instr_ready_out |=> (s_q.ph == nmn_pkg::PH_Q1) ##1 !done_out
         ##1 !done_out ##1 done_out;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("phase sequence wrong");

   property p_mul_only_prod;
      prod_we_out |-> !mem_wr_out && !flags_we_out ##1 $stable(flags_out);
   endproperty
   a_mul_only_prod: assert property (p_mul_only_prod) else $error("multiply wrote more");

   property p_mul_value;
      (s_q.ph == nmn_pkg::PH_Q3) && (s_q.op == nmn_pkg::OP_MUL)
         |-> ##2 {product_high_byte_out, product_low_byte_out}
            == 16'($past(w_in, 2)) * 16'($past(mem_rdata_in, 2));
   endproperty
   a_mul_value: assert property (p_mul_value) else $error("product wrong");

   property p_nop_quiet;
      (s_q.ph == nmn_pkg::PH_Q2) && (s_q.op == nmn_pkg::OP_NOP)
         |-> (!mem_rd_out && !mem_wr_out && !prod_we_out && !flags_we_out) [*3];
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("no-op touched state");

   c_neg: cover property (mem_wr_out && flags_out[nmn_pkg::FLG_OV] == 1'b0);
   c_mul: cover property (prod_we_out);
   c_back2back: cover property (done_out && instr_valid_in ##4 done_out);
endmodule
`default_nettype wire

//--- tb/nmn_mem_model.sv
// data memory partner: answers one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module nmn_mem_model (
   input wire logic core_clk_in,
   input wire logic [11:0] mem_addr_in,
   input wire logic mem_rd_in,
   input wire logic mem_wr_in,
   input wire logic [7:0] mem_wdata_in,
   output logic [7:0] mem_rdata_out
);
   logic [7:0] mem [4096];
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 37 + 5);
      end
      mem_rdata_out = 8'h5A;
   end
   // toggles outside the answer cycle so stale data never passes as valid
   always @(posedge core_clk_in) begin
      mem_rdata_out <= mem_rd_in ? mem[mem_addr_in] : ~mem_rdata_out;
      if (mem_wr_in) begin
         mem[mem_addr_in] <= mem_wdata_in;
      end
   end
endmodule
`default_nettype wire

//--- tb/test_negate_multiply_nop_exec.sv
// self-checking bench for the negate/multiply/no-op executor
`timescale 1ns/1ps
`default_nettype none
module test_negate_multiply_nop_exec;
   logic core_clk_in, rst_in, instr_valid_in, ext_set_in, rdy, rd, wr, fwe, pwe, done;
   logic [15:0] instr_word_in;
   logic [3:0] bank_in;
   logic [11:0] base_in, addr;
   logic [7:0] w_in, rdata, wdata, ph, pl;
   logic [4:0] flags;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 72761;
   logic [7:0] ref_mem [4096];
   logic [4:0] exp_flags = 5'h00;
   logic [15:0] exp_prod = 16'h0000;
   logic [31:0] rv;
   nmn_exec nmn_exec_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
      .bank_select_register_in(bank_in), .ext_set_in(ext_set_in), .index_base_in(base_in),
      .w_in(w_in), .mem_rdata_in(rdata), .instr_ready_out(rdy), .mem_addr_out(addr),
      .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdata), .flags_out(flags),
      .flags_we_out(fwe), .product_high_byte_out(ph), .product_low_byte_out(pl),
      .prod_we_out(pwe), .done_out(done));
   nmn_mem_model nmn_mem_model_inst (.core_clk_in(core_clk_in), .mem_addr_in(addr),
      .mem_rd_in(rd), .mem_wr_in(wr), .mem_wdata_in(wdata), .mem_rdata_out(rdata));
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [11:0] eff(input logic [15:0] wd, input logic [3:0] bk,
                                       input logic ex, input logic [11:0] bs);
      if (wd[8]) return {bk, wd[7:0]};
      if (ex && wd[7:0] <= 8'h5F) return bs + {4'h0, wd[7:0]};
      return {(wd[7] ? 4'hF : 4'h0), wd[7:0]};
   endfunction
   task automatic poke(input logic [11:0] a, input logic [7:0] v);
      ref_mem[a] = v;
      nmn_mem_model_inst.mem[a] = v;
   endtask
   task automatic exec(input logic [15:0] wd, input logic [3:0] bk, input logic ex,
                       input logic [11:0] bs, input logic [7:0] w);
      logic [11:0] a;
      logic [7:0] v, r;
      int op, n, strobes;
      a = eff(wd, bk, ex, bs);
      v = ref_mem[a];
      op = (wd[15:9] == nmn_pkg::OPC_NEG_F) ? 2 : (wd[15:9] == nmn_pkg::OPC_MUL_F) ? 1 : 0;
      strobes = 0;
      @(negedge core_clk_in);
      for (n = 0; n < 8 && rdy !== 1'b1; n++) @(negedge core_clk_in);
      if (rdy !== 1'b1) begin
         num_errors++;
         $display("FAIL t=%0t never ready", $time);
         results();
      end
      instr_valid_in = 1'b1;
      instr_word_in = wd;
      bank_in = bk;
      ext_set_in = ex;
      base_in = bs;
      w_in = w;
      for (n = 1; n <= 8; n++) begin
         @(negedge core_clk_in);
         instr_valid_in = 1'b0;
         strobes += int'(wr === 1'b1 || fwe === 1'b1 || pwe === 1'b1);
         if (rd === 1'b1) begin
            chk(16'(addr), 16'(a), "operand address");
            chk(16'(n), (op == 0) ? 16'h00FF : 16'h0002, "read phase");
         end
         if (done === 1'b1) break;
      end
      if (n > 8) begin
         num_errors++;
         $display("FAIL t=%0t no completion", $time);
         results();
      end
      chk(16'(n), 16'h0004, "cycle count");
      chk({13'h0, wr, fwe, pwe}, (op == 2) ? 16'h0006 : 16'(op == 1), "strobes");
      chk(16'(strobes), 16'(op != 0), "strobe cycles");
      if (op == 2) begin
         r = 8'(-v);
         exp_flags = {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
         ref_mem[a] = r;
         chk(16'(wdata), 16'(r), "negated byte");
      end else if (op == 1) begin
         exp_prod = 16'(w) * 16'(v);
      end
      @(negedge core_clk_in);
      chk(16'(flags), 16'(exp_flags), "flags");
      chk({ph, pl}, exp_prod, "product");
   endtask
   logic [7:0] vals [7] = '{8'h00, 8'h80, 8'h3A, 8'h01, 8'h10, 8'hFF, 8'h7F};
   logic [15:0] nw [5] = '{16'h6C05, 16'h6C90, 16'h6C5F, 16'h6C60, 16'h6DAB};
   logic [15:0] nops [4] = '{16'h0000, 16'hF000, 16'hFFFF, 16'hF123};
   initial begin
      rst_in = 1'b1;
      {instr_valid_in, ext_set_in, instr_word_in, bank_in, base_in, w_in} = '0;
      for (int i = 0; i < 4096; i++) ref_mem[i] = 8'(i * 37 + 5);
      repeat (12) @(negedge core_clk_in);
      rst_in = 1'b0;
      chk({3'h0, rdy, flags, pl[6:0]}, 16'h1000, "reset state");
      poke(12'h210, 8'hB5);
      exec(16'h0310, 4'h2, 1'b0, 12'h000, 8'hC4);
      chk({ph, pl}, 16'h8A94, "worked product");
      $display("test multiply example done");
      for (int i = 0; i < 7; i++) begin
         poke(eff(nw[i % 5], 4'(i + 3), i[0], 12'hFC0), vals[i]);
         exec(nw[i % 5], 4'(i + 3), i[0], 12'hFC0, 8'h11);
      end
      $display("test negate table done");
      exec(16'h6C05, 4'h0, 1'b0, 12'h000, 8'h03);
      exec(16'h0205, 4'h0, 1'b0, 12'h000, 8'hFF);
      exec(16'h0205, 4'h0, 1'b0, 12'h000, 8'h02);
      $display("test write back done");
      foreach (nops[i]) exec(nops[i], 4'h1, 1'b1, 12'h100, 8'h55);
      // second word offered in the write phase of the first
      @(negedge core_clk_in);
      {instr_valid_in, instr_word_in} = {1'b1, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         @(negedge core_clk_in);
         chk(16'(done), 16'(i == 3 || i == 7), "back-to-back done");
         instr_valid_in = (i == 3);
      end
      $display("test back-to-back done");
      $display("test no-op words done");
      for (int i = 0; i < 80; i++) begin
         rv = $random(seed);
         case (rv[17:16])
            2'd0: instr_word_in = {nmn_pkg::OPC_NEG_F, rv[8:0]};
            2'd1: instr_word_in = {nmn_pkg::OPC_MUL_F, rv[8:0]};
            default: instr_word_in = {4'hF, rv[11:0]};
         endcase
         exec(instr_word_in, rv[23:20], rv[24], {rv[31:28], rv[27:20]}, rv[15:8]);
      end
      $display("test random mix done");
      results();
   end
endmodule
`default_nettype wire
